// >>> pkg/rdp_pkg.sv
package rdp_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL_A = 8'h00;
   localparam logic [7:0] OFF_CTRL_B = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_DELAY  = 8'h0C;
   localparam logic [7:0] OFF_EXPECT = 8'h10;

   // detect_control_a fields
   localparam int A_HALT  = 7;
   localparam int A_GO    = 6;
   localparam int A_T3    = 5;
   localparam int A_T2    = 4;
   localparam int A_NUM   = 3;
   localparam int A_RECNT = 2;
   localparam int A_METH  = 1;
   localparam int A_EN    = 0;

   // detect_control_b fields
   localparam int B_TICK = 6;
   localparam int B_MODE = 4;
   localparam int B_CNT  = 0;

   // Status fields
   localparam int S_EDGE = 4;
   localparam int S_ACT  = 3;
   localparam int S_PAT  = 0;

   // Reset values
   localparam logic [5:0] CTRL_A_RST = 6'h00;
   localparam logic [7:0] CTRL_B_RST = 8'h00;
   localparam logic [6:0] DELAY_RST  = 7'h00;
   localparam logic [2:0] EXPECT_RST = 3'h0;

   // Sampling modes
   localparam logic [1:0] MODE_PWM = 2'h0;
   localparam logic [1:0] MODE_REG = 2'h1;
   localparam logic [1:0] MODE_LOW = 2'h2;

   // Tick select: fc/8, fc/16, fc/32
   localparam logic [1:0] TICK_8  = 2'h0;
   localparam logic [1:0] TICK_16 = 2'h1;
   localparam logic [4:0] MASK_8  = 5'h07;
   localparam logic [4:0] MASK_16 = 5'h0F;
   localparam logic [4:0] MASK_32 = 5'h1F;

   // Edge flag codes
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_RST  = 2'h0;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN  = 2'b10
   } rdp_state_t;
endpackage

// >>> pkg/rdp_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rdp_tick_if;
   logic [1:0] sel;
   logic       tick;
   modport gen  (input sel, output tick);
   modport user (output sel, input tick);
endinterface
`default_nettype wire

// >>> rtl/rdp_detector.sv
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] Ordinary mode: match with expected pattern raises event and stops sampling.
// [RULE2] Mismatch mode: latch inputs at start, detect when inputs differ.
// [RULE3] Latched start pattern readable in status bits 2..0.
// [RULE4] Timer mode: second timer starts sampling, third timer stops it.
// [RULE5] When enabled, sampling starts on second-timer trigger or software start.
// [RULE6] Mode field bits 5..4: PWM-on, continuous, or lower-side conduction.
// [RULE7] Software must program equal duty on all phases for PWM-on mode.
// [RULE8] Lower-side mode samples a phase from delay expiry until conduction ends.
// [RULE9] Phases sample independently, hold while idle; held samples join the match.
// [RULE10] PWM-on and lower-side modes suppress sampling for programmed delay.
// [RULE11] Recount restarts match count each PWM-on period; else count accumulates.
// [RULE12] Status bit 5 set on detection at PWM fall, bit 4 at rise.
// [RULE13] Status bit 3 reads 1 while sampling, 0 when idle.
// [RULE14] Bits 7..6 pick sample tick of clock divided by 8, 16, 32.
// [RULE15] Ordinary mode detects after consecutive matches reach count field bits 3..0.
// [RULE16] Mismatch mode detects after consecutive mismatches reach the count.
// [RULE17] Any of six three-phase expected patterns compared on all phases.
// [RULE18] Control bit 1 selects ordinary or mismatch detection.
// [RULE19] Control bit 0 enables the whole detection function.
// [RULE20] Seven-bit delay field holds the post-PWM-on suppression time.
// [RULE21] Control bit 3 selects single input; V and W expectations ignored.
// [RULE22] Interrupt is a one-cycle pulse; edge flags update the same cycle.
module rdp_detector (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Position inputs
   input  wire logic        phase_u_input,
   input  wire logic        phase_v_input,
   input  wire logic        phase_w_input,
   // Motor unit signals
   input  wire logic [2:0]  pwm_on,
   input  wire logic [2:0]  lower_on,
   input  wire logic        timer2_trig,
   input  wire logic        timer3_trig,
   // Event
   output logic             position_found_irq
);
   logic [5:0]  ctrl_a_reg, ctrl_a_next;
   logic        go_reg, go_next;
   logic        halt_reg, halt_next;
   logic [7:0]  ctrl_b_reg, ctrl_b_next;
   logic [6:0]  dly_reg, dly_next;
   logic [2:0]  exp_reg, exp_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   logic [31:0] rd;
   logic        map_hit, acc, done;

   rdp_pkg::rdp_state_t state_reg, state_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic [2:0]  pat_reg, pat_next;
   logic [1:0]  edge_reg, edge_next;
   logic        irq_reg, irq_next;
   logic        pwm_d_reg;

   logic        en, meth, single, recnt, t2en, t3en;
   logic [1:0]  mode;
   logic [3:0]  lim, base, inc;
   logic        pwm_any, running, start, stop, recnt_clr, cmp, match, same, hit, detect;
   logic [2:0]  pin, msk, gate, smp, upd;
   logic [6:0]  dly_use;

   rdp_tick_if tif ();

   // Control decode
   assign en      = ctrl_a_reg[rdp_pkg::A_EN];
   assign meth    = ctrl_a_reg[rdp_pkg::A_METH];
   assign recnt   = ctrl_a_reg[rdp_pkg::A_RECNT];
   assign single  = ctrl_a_reg[rdp_pkg::A_NUM];
   assign t2en    = ctrl_a_reg[rdp_pkg::A_T2];
   assign t3en    = ctrl_a_reg[rdp_pkg::A_T3];
   assign mode    = ctrl_b_reg[rdp_pkg::B_MODE +: 2];
   assign lim     = ctrl_b_reg[rdp_pkg::B_CNT +: 4];
   assign tif.sel = ctrl_b_reg[rdp_pkg::B_TICK +: 2]; // see [RULE14]
   assign pin     = {phase_w_input, phase_v_input, phase_u_input};
   assign pwm_any = |pwm_on; // see [RULE11]
   assign running = state_reg == rdp_pkg::ST_RUN;

   // Read mux
   always_comb begin
      rd      = 32'h0000_0000;
      map_hit = 1'b1;
      case (paddr)
         rdp_pkg::OFF_CTRL_A: rd[5:0] = ctrl_a_reg;
         rdp_pkg::OFF_CTRL_B: rd[7:0] = ctrl_b_reg;
         rdp_pkg::OFF_STATUS: rd[5:0] = {edge_reg, running, pat_reg}; // see [RULE3] [RULE13]
         rdp_pkg::OFF_DELAY:  rd[6:0] = dly_reg;
         rdp_pkg::OFF_EXPECT: rd[2:0] = exp_reg;
         default:             map_hit = 1'b0;
      endcase
   end

   // APB access, one wait state, writes at completion
   always_comb begin
      acc          = psel && penable && !pready_reg;
      done         = psel && penable && pready_reg;
      pready_next  = acc;
      prdata_next  = acc ? rd : prdata_reg;
      pslverr_next = acc && !map_hit;
      ctrl_a_next  = ctrl_a_reg;
      ctrl_b_next  = ctrl_b_reg;
      dly_next     = dly_reg;
      exp_next     = exp_reg;
      go_next      = 1'b0;
      halt_next    = 1'b0;
      if (done && pwrite && map_hit) begin
         case (paddr)
            rdp_pkg::OFF_CTRL_A: begin
               ctrl_a_next = pwdata[5:0]; // see [RULE18] [RULE19] [RULE21]
               go_next     = pwdata[rdp_pkg::A_GO];
               halt_next   = pwdata[rdp_pkg::A_HALT];
            end
            rdp_pkg::OFF_CTRL_B: ctrl_b_next = pwdata[7:0]; // see [RULE6]
            rdp_pkg::OFF_DELAY:  dly_next    = pwdata[6:0]; // see [RULE20]
            rdp_pkg::OFF_EXPECT: exp_next    = pwdata[2:0]; // see [RULE17]
            default:             ctrl_a_next = ctrl_a_reg;
         endcase
      end
   end

   // Register file
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_a_reg  <= rdp_pkg::CTRL_A_RST;
         ctrl_b_reg  <= rdp_pkg::CTRL_B_RST;
         dly_reg     <= rdp_pkg::DELAY_RST;
         exp_reg     <= rdp_pkg::EXPECT_RST;
         go_reg      <= 1'b0;
         halt_reg    <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         ctrl_a_reg  <= ctrl_a_next;
         ctrl_b_reg  <= ctrl_b_next;
         dly_reg     <= dly_next;
         exp_reg     <= exp_next;
         go_reg      <= go_next;
         halt_reg    <= halt_next;
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Sampling window per phase; continuous mode never waits on a delay
   always_comb begin
      dly_use = 7'h00;
      case (mode)
         rdp_pkg::MODE_LOW: begin
            gate    = lower_on; // see [RULE8]
            dly_use = dly_reg; // see [RULE10]
         end
         rdp_pkg::MODE_PWM: begin
            gate    = {3{pwm_any}};
            dly_use = dly_reg; // see [RULE10]
         end
         default: gate = 3'b111;
      endcase
   end

   rdp_tick_gen u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tif     (tif.gen)
   );

   // One delay and hold stage per phase
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_ph
         rdp_phase_gate #(.DW(7)) u_gate (
            .pclk    (pclk),
            .presetn (presetn),
            .gate    (gate[gi]),
            .dly     (dly_use),
            .tick    (tif.tick),
            .din     (pin[gi]),
            .smp     (smp[gi]),
            .upd     (upd[gi])
         );
      end
   endgenerate

   // Detection engine
   always_comb begin
      msk        = single ? 3'b001 : 3'b111; // see [RULE21]
      match      = ((smp ^ exp_reg) & msk) == 3'b000; // see [RULE9] [RULE17]
      same       = ((smp ^ pat_reg) & msk) == 3'b000;
      hit        = meth ? !same : match; // see [RULE2] [RULE18]
      cmp        = |upd;
      start      = en && (go_reg || (t2en && timer2_trig)); // see [RULE5] [RULE19]
      stop       = halt_reg || (t3en && timer3_trig) || !en; // see [RULE4]
      recnt_clr  = recnt && mode != rdp_pkg::MODE_REG && pwm_any && !pwm_d_reg; // see [RULE11]
      base       = recnt_clr ? 4'h0 : cnt_reg;
      inc        = (base == 4'hF) ? 4'hF : base + 4'h1;
      detect     = 1'b0;
      state_next = state_reg;
      cnt_next   = cnt_reg;
      pat_next   = pat_reg;
      edge_next  = edge_reg;
      irq_next   = 1'b0;
      case (state_reg)
         rdp_pkg::ST_IDLE: begin
            if (start) begin
               state_next = rdp_pkg::ST_RUN;
               cnt_next   = 4'h0;
               pat_next   = pin; // see [RULE2]
            end
         end
         rdp_pkg::ST_RUN: begin
            cnt_next = base;
            if (cmp) begin
               cnt_next = hit ? inc : 4'h0;
               detect   = hit && inc >= lim; // see [RULE15] [RULE16]
            end
            if (detect) begin
               irq_next   = 1'b1; // see [RULE22]
               edge_next  = pwm_any ? rdp_pkg::EDGE_RISE : rdp_pkg::EDGE_FALL; // see [RULE12]
               state_next = rdp_pkg::ST_IDLE; // see [RULE1]
            end else if (stop) begin
               state_next = rdp_pkg::ST_IDLE;
            end
         end
         default: state_next = rdp_pkg::ST_IDLE;
      endcase
   end

   // Engine registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= rdp_pkg::ST_IDLE;
         cnt_reg   <= 4'h0;
         pat_reg   <= 3'h0;
         edge_reg  <= rdp_pkg::EDGE_RST;
         irq_reg   <= 1'b0;
         pwm_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         pat_reg   <= pat_next;
         edge_reg  <= edge_next;
         irq_reg   <= irq_next;
         pwm_d_reg <= pwm_any;
      end
   end

   assign prdata             = prdata_reg;
   assign pready             = pready_reg;
   assign pslverr            = pslverr_reg;
   assign position_found_irq = irq_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_stop_hit;
      detect && !meth |=> state_reg == rdp_pkg::ST_IDLE && irq_reg;
   endproperty
   a_stop_hit: assert property (p_stop_hit) else $error("no stop on match"); // see [RULE1]

   property p_latch;
      state_reg == rdp_pkg::ST_IDLE && start |=> pat_reg == $past(pin) && running;
   endproperty
   a_latch: assert property (p_latch) else $error("start pattern not latched"); // see [RULE2]

   property p_pat_read;
      pready_reg && !pwrite && paddr == rdp_pkg::OFF_STATUS |-> prdata_reg[2:0] == $past(pat_reg);
   endproperty
   a_pat_read: assert property (p_pat_read) else $error("pattern read wrong"); // see [RULE3]

   property p_act_read;
      pready_reg && !pwrite && paddr == rdp_pkg::OFF_STATUS |-> prdata_reg[3] == $past(running);
   endproperty
   a_act_read: assert property (p_act_read) else $error("active bit wrong"); // see [RULE13]

   property p_t3_stop;
      running && t3en && timer3_trig && !detect |=> state_reg == rdp_pkg::ST_IDLE;
   endproperty
   a_t3_stop: assert property (p_t3_stop) else $error("timer stop ignored"); // see [RULE4]

   property p_t2_start;
      !running && en && t2en && timer2_trig |=> running;
   endproperty
   a_t2_start: assert property (p_t2_start) else $error("timer start ignored"); // see [RULE5]

   property p_off;
      !running && !en |=> !running;
   endproperty
   a_off: assert property (p_off) else $error("ran while disabled"); // see [RULE19]

   property p_pulse;
      irq_reg |=> !irq_reg;
   endproperty
   a_pulse: assert property (p_pulse) else $error("event not a pulse"); // see [RULE22]

   property p_edge;
      irq_reg |-> edge_reg == ($past(pwm_any) ? rdp_pkg::EDGE_RISE : rdp_pkg::EDGE_FALL);
   endproperty
   a_edge: assert property (p_edge) else $error("edge flags wrong"); // see [RULE12]

   property p_count;
      irq_reg |-> $past(inc) >= $past(lim) && $past(hit) && $past(cmp);
   endproperty
   a_count: assert property (p_count) else $error("early detection"); // see [RULE15]

   c_ord: cover property (irq_reg && !meth);
   c_mis: cover property (irq_reg && meth);
   c_low: cover property (irq_reg && mode == rdp_pkg::MODE_LOW);
   c_t3:  cover property (running && t3en && timer3_trig ##1 !running);
endmodule
`default_nettype wire

// >>> rtl/rdp_phase_gate.sv
`timescale 1ns/1ps
`default_nettype none
module rdp_phase_gate #(
   parameter int DW = 7
) (
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // Window control
   input  wire logic          gate,
   input  wire logic [DW-1:0] dly,
   input  wire logic          tick,
   // Phase data
   input  wire logic          din,
   output logic               smp,
   output logic               upd
);
   logic          gate_d_reg;
   logic [DW-1:0] cnt_reg, cnt_next;
   logic          smp_reg, smp_next;
   logic          upd_reg, upd_next;
   logic          open;

   // Delay after window opens, then sample on ticks, hold otherwise
   always_comb begin
      cnt_next = cnt_reg;
      if (gate && !gate_d_reg)
         cnt_next = dly; // see [RULE10]
      else if (tick && cnt_reg != '0)
         cnt_next = cnt_reg - 1'b1;
      open     = gate && gate_d_reg && cnt_reg == '0; // see [RULE8]
      upd_next = tick && open;
      smp_next = upd_next ? din : smp_reg; // see [RULE9]
   end

   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_d_reg <= 1'b0;
         cnt_reg    <= '0;
         smp_reg    <= 1'b0;
         upd_reg    <= 1'b0;
      end else begin
         gate_d_reg <= gate;
         cnt_reg    <= cnt_next;
         smp_reg    <= smp_next;
         upd_reg    <= upd_next;
      end
   end

   assign smp = smp_reg;
   assign upd = upd_reg;

   property p_delay_quiet;
      @(posedge pclk) disable iff (!presetn)
      (gate && !gate_d_reg && dly != '0) |=> !upd_reg [*2];
   endproperty
   a_delay_quiet: assert property (p_delay_quiet) else $error("sample inside delay"); // see [RULE10]
endmodule
`default_nettype wire

// >>> rtl/rdp_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module rdp_tick_gen (
   // Clock and reset
   input  wire logic    pclk,
   input  wire logic    presetn,
   // Tick link
   rdp_tick_if.gen      tif
);
   logic [4:0] cnt_reg, cnt_next;
   logic       tick_reg, tick_next;
   logic [4:0] mask;

   // Prescaler and tick decode
   always_comb begin
      case (tif.sel)
         rdp_pkg::TICK_8:  mask = rdp_pkg::MASK_8;
         rdp_pkg::TICK_16: mask = rdp_pkg::MASK_16;
         default:          mask = rdp_pkg::MASK_32;
      endcase
      cnt_next  = cnt_reg + 5'h01;
      tick_next = (cnt_reg & mask) == mask; // see [RULE14]
   end

   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg  <= 5'h00;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tif.tick = tick_reg;

   property p_tick_gap;
      @(posedge pclk) disable iff (!presetn)
      tick_reg |=> !tick_reg [*7];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick period below 8"); // see [RULE14]
endmodule
`default_nettype wire

// >>> verif/rdp_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
// Motor side: winding or sensor levels from a commanded pattern
module rdp_motor_model (
   // Clock
   input  wire logic       pclk,
   // Commanded pattern, W V U
   input  wire logic [2:0] pat,
   // Position inputs
   output logic            pu,
   output logic            pv,
   output logic            pw
);
   // Levels move only just after a clock edge
   always @(posedge pclk) begin
      {pw, pv, pu} <= pat;
   end
endmodule
`default_nettype wire

// >>> verif/test_rotor_position_detector.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_rotor_position_detector;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic        pu, pv, pw, irq, t2, t3, er;
   logic [2:0]  pat, pwm, low;
   int          fails, samples_checked, seed, lat, nirq, exp_irq, lim, h, per;

   rdp_detector uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .phase_u_input(pu),
      .phase_v_input(pv), .phase_w_input(pw), .pwm_on(pwm), .lower_on(low),
      .timer2_trig(t2), .timer3_trig(t3), .position_found_irq(irq)
   );
   rdp_motor_model motor (.pclk(pclk), .pat(pat), .pu(pu), .pv(pv), .pw(pw));

   // Clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Event pulse counter
   always @(negedge pclk) if (irq === 1'b1) nirq++;

   // One APB transfer, answer taken at the edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      if (n >= 50) fails++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Wait for the event pulse, then confirm it lasted one cycle
   task automatic wait_irq(input int mx);
      lat = 0;
      do begin
         @(negedge pclk);
         lat++;
      end while (irq !== 1'b1 && lat < mx);
      exp_irq++;
      @(negedge pclk);
      `CHK(irq, 1'b0)
      `CHK(nirq, exp_irq)
   endtask

   // PWM pulses of six clocks on and six off, equal on all phases
   task automatic pulses(input int k);
      repeat (k) begin
         pwm <= 3'h7;
         repeat (6) @(posedge pclk);
         pwm <= 3'h0;
         repeat (6) @(posedge pclk);
      end
   endtask

   // Pulse a timer trigger line
   task automatic trig(input logic which);
      @(posedge pclk);
      if (which) t3 <= 1'b1;
      else t2 <= 1'b1;
      @(posedge pclk);
      t2 <= 1'b0;
      t3 <= 1'b0;
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (60000) @(posedge pclk);
      fails++;
      finish_test();
   end

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, t2, t3} = '0;
      {paddr, pwdata, pat, pwm, low} = '0;
      {fails, samples_checked, nirq, exp_irq} = '0;
      seed = 32'h3412;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, read-only status, unmapped place
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         `CHK(rd, 32'h0)
      end
      apb(1'b0, 8'h14, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      apb(1'b1, rdp_pkg::OFF_STATUS, 32'hFF);
      apb(1'b0, rdp_pkg::OFF_STATUS, 32'h0);
      `CHK(rd, 32'h0)
      v = $random(seed);
      apb(1'b1, rdp_pkg::OFF_CTRL_B, v);
      apb(1'b0, rdp_pkg::OFF_CTRL_B, 32'h0);
      `CHK(rd, {24'h0, v[7:0]})
      apb(1'b1, rdp_pkg::OFF_DELAY, v);
      apb(1'b0, rdp_pkg::OFF_DELAY, 32'h0);
      `CHK(rd, {25'h0, v[6:0]})
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'hFE);
      apb(1'b0, rdp_pkg::OFF_CTRL_A, 32'h0);
      `CHK(rd, 32'h3E)
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h40);
      apb(1'b0, rdp_pkg::OFF_STATUS, 32'h0);
      `CHK(rd[3], 1'b0)
      // Ordinary detection over every tick rate and pattern
      for (int tk = 0; tk < 3; tk++) begin
         for (int m = 1; m < 7; m++) begin
            lim = {$random(seed)} % 16;
            per = 8 << tk;
            h = (lim < 2) ? 1 : lim;
            apb(1'b1, rdp_pkg::OFF_CTRL_B, 32'({tk[1:0], rdp_pkg::MODE_REG, lim[3:0]}));
            apb(1'b1, rdp_pkg::OFF_EXPECT, 32'(m));
            pat <= ~m[2:0];
            apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h41);
            repeat (3 * per) @(posedge pclk);
            apb(1'b0, rdp_pkg::OFF_STATUS, 32'h0);
            `CHK({rd[3], nirq}, {1'b1, exp_irq})
            pat <= m[2:0];
            wait_irq(1000);
            `CHK(lat >= (h - 1) * per && lat <= h * per + 8, 1'b1)
            apb(1'b0, rdp_pkg::OFF_STATUS, 32'h0);
            `CHK(rd[3], 1'b0)
         end
      end
      // Mismatch detection against the start pattern
      apb(1'b1, rdp_pkg::OFF_CTRL_B, 32'({2'h0, rdp_pkg::MODE_REG, 4'h3}));
      pat <= 3'h5;
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h43);
      repeat (60) @(posedge pclk);
      apb(1'b0, rdp_pkg::OFF_STATUS, 32'h0);
      `CHK({rd[2:0], nirq}, {3'h5, exp_irq})
      pat <= 3'h2;
      wait_irq(200);
      `CHK(lat >= 16 && lat <= 32, 1'b1)
      // Timer start and stop, software stop
      apb(1'b1, rdp_pkg::OFF_EXPECT, 32'h3);
      pat <= 3'h4;
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h31);
      trig(1'b0);
      apb(1'b0, rdp_pkg::OFF_STATUS, 32'h0);
      `CHK(rd[3], 1'b1)
      trig(1'b1);
      apb(1'b0, rdp_pkg::OFF_STATUS, 32'h0);
      `CHK(rd[3], 1'b0)
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h41);
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h81);
      apb(1'b0, rdp_pkg::OFF_STATUS, 32'h0);
      `CHK({rd[3], nirq}, {1'b0, exp_irq})
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h11);
      pat <= 3'h3;
      trig(1'b0);
      wait_irq(200);
      // Single input: only U is compared
      apb(1'b1, rdp_pkg::OFF_EXPECT, 32'h1);
      pat <= 3'h7;
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h49);
      wait_irq(200);
      // Recount: one sample per pulse never reaches a limit of two
      apb(1'b1, rdp_pkg::OFF_CTRL_B, 32'({2'h0, rdp_pkg::MODE_PWM, 4'h2}));
      apb(1'b1, rdp_pkg::OFF_DELAY, 32'h0);
      apb(1'b1, rdp_pkg::OFF_EXPECT, 32'h5);
      pat <= 3'h5;
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h45);
      pulses(20);
      `CHK(nirq, exp_irq)
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h01);
      pulses(20);
      exp_irq++;
      `CHK(nirq, exp_irq)
      // PWM-on mode with delay, then lower-side mode
      apb(1'b1, rdp_pkg::OFF_CTRL_B, 32'({2'h0, rdp_pkg::MODE_PWM, 4'h1}));
      apb(1'b1, rdp_pkg::OFF_DELAY, 32'h2);
      apb(1'b1, rdp_pkg::OFF_EXPECT, 32'h6);
      pat <= 3'h6;
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h41);
      repeat (100) @(posedge pclk);
      `CHK(nirq, exp_irq)
      pwm <= 3'h7;
      wait_irq(200);
      `CHK(lat >= 16, 1'b1)
      apb(1'b0, rdp_pkg::OFF_STATUS, 32'h0);
      `CHK(rd[5:4], rdp_pkg::EDGE_RISE)
      apb(1'b1, rdp_pkg::OFF_CTRL_B, 32'({2'h0, rdp_pkg::MODE_LOW, 4'h1}));
      pwm <= 3'h0;
      low <= 3'h7;
      apb(1'b1, rdp_pkg::OFF_CTRL_A, 32'h41);
      wait_irq(200);
      apb(1'b0, rdp_pkg::OFF_STATUS, 32'h0);
      `CHK(rd[5:4], rdp_pkg::EDGE_FALL)
      finish_test();
   end
endmodule
`default_nettype wire
